/* logic/durd_regsel.sv */
// Host register select and storage for both channels of the dual serial port
//
// Overview of operation
// - Each channel owns its register set; chip and channel selects pick it.
// - Divisor bit clear: address 0 reads receive data, writes transmit data.
// - Divisor bit set, not bank key: addresses 0-2 reach divisor bytes, alt function.
// - Divisor bytes zero in divisor view: reads at 0 and 1 give revision, identity.
// - Divisor bit clear: address 1 reaches interrupt enable, read and write.
// - Divisor bit clear: address 2 reads interrupt status, writes FIFO control.
// - Address 3 always reaches line control, whatever it holds.
// - Outside the enhanced bank, address 4 reaches modem control.
// - Not bank key: address 5 reads line status; writes there are reserved.
// - Outside the enhanced bank: address 6 reads modem status; writes reserved.
// - Not bank key, swap bit clear: address 7 is the scratch pad.
// - Not bank key, swap bit set: address 7 reads fill level, writes mode select.
// - Bank key: address 0 writes trigger level, reads enhanced FIFO count.
// - Bank key: addresses 1 and 2 reach feature control and enhanced function.
// - Bank key: addresses 4-7 reach resume one, resume two, pause one, pause two.
// - Upper enable, status, FIFO trigger and modem bits act only with enhance bit set.
`timescale 1ns/1ps
`default_nettype none

module durd_regsel #(
  parameter logic [7:0] DEV_REVISION = 8'h01, // Arbitrary value
  parameter logic [7:0] DEV_IDENTITY = 8'h3C  // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Host bus
  input wire logic cs_b,
  input wire logic channel_select,
  input wire logic [2:0] reg_addr,
  input wire logic rd_b,
  input wire logic wr_b,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data_q,
  // Channel side
  input wire durd_pkg::durd_stat_t [durd_pkg::NUM_CHAN-1:0] chan_stat,
  output durd_pkg::durd_cfg_t [durd_pkg::NUM_CHAN-1:0] chan_cfg_q,
  output durd_pkg::durd_evt_t [durd_pkg::NUM_CHAN-1:0] chan_evt_q
);

  // Every property samples on the system clock and rests during reset
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [7:0] gate(input logic [7:0] value, input logic [7:0] mask,
                                      input logic enable);
    gate = enable ? value : (value & ~mask);
  endfunction

  function automatic durd_pkg::durd_tgt_t decode(input logic is_wr, input logic [2:0] adr,
                                                 input durd_pkg::durd_cfg_t c);
    logic bank;
    logic div;
    logic dl_zero;
    logic swap;
    bank = (c.line_control == durd_pkg::BANK_KEY);
    div = c.line_control[durd_pkg::DIV_EN_BIT];
    dl_zero = (c.divisor_low_byte == durd_pkg::DIV_ZERO) &&
              (c.divisor_high_byte == durd_pkg::DIV_ZERO);
    swap = c.feature_control[durd_pkg::SWAP_BIT];
    decode = durd_pkg::TGT_NONE;
    unique case (adr)
      durd_pkg::ADR_HOLD: begin
        if (bank) begin
          decode = is_wr ? durd_pkg::TGT_TRIG_LEVEL : durd_pkg::TGT_ENH_COUNT;
        end else if (div) begin
          decode = (!is_wr && dl_zero) ? durd_pkg::TGT_REVISION : durd_pkg::TGT_DIV_LO;
        end else begin
          decode = is_wr ? durd_pkg::TGT_TX_HOLD : durd_pkg::TGT_RX_HOLD;
        end
      end
      durd_pkg::ADR_INT_EN: begin
        if (bank) begin
          decode = durd_pkg::TGT_FEAT_CTRL;
        end else if (div) begin
          decode = (!is_wr && dl_zero) ? durd_pkg::TGT_IDENTITY : durd_pkg::TGT_DIV_HI;
        end else begin
          decode = durd_pkg::TGT_INT_EN;
        end
      end
      durd_pkg::ADR_INT_STAT: begin
        if (bank) begin
          decode = durd_pkg::TGT_ENH_FUNC;
        end else if (div) begin
          decode = durd_pkg::TGT_ALT_FUNC;
        end else begin
          decode = is_wr ? durd_pkg::TGT_FIFO_CTRL : durd_pkg::TGT_INT_STAT;
        end
      end
      durd_pkg::ADR_LINE_CTRL: begin
        decode = durd_pkg::TGT_LINE_CTRL;
      end
      durd_pkg::ADR_MODEM_CTRL: begin
        decode = bank ? durd_pkg::TGT_RESUME1 : durd_pkg::TGT_MODEM_CTRL;
      end
      durd_pkg::ADR_LINE_STAT: begin
        if (bank) begin
          decode = durd_pkg::TGT_RESUME2;
        end else begin
          decode = is_wr ? durd_pkg::TGT_NONE : durd_pkg::TGT_LINE_STAT;
        end
      end
      durd_pkg::ADR_MODEM_STAT: begin
        if (bank) begin
          decode = durd_pkg::TGT_PAUSE1;
        end else begin
          decode = is_wr ? durd_pkg::TGT_NONE : durd_pkg::TGT_MODEM_STAT;
        end
      end
      durd_pkg::ADR_SCRATCH: begin
        if (bank) begin
          decode = durd_pkg::TGT_PAUSE2;
        end else if (swap) begin
          decode = is_wr ? durd_pkg::TGT_MODE_SEL : durd_pkg::TGT_FILL_LEVEL;
        end else begin
          decode = durd_pkg::TGT_SCRATCH;
        end
      end
    endcase
  endfunction

  // ************************************************************
  // Strobe edges and channel pick
  // ************************************************************
  logic rd_b_q;
  logic wr_b_q;
  logic rd_go;
  logic wr_go;
  logic [durd_pkg::NUM_CHAN-1:0] ch_hit;
  durd_pkg::durd_cfg_t [durd_pkg::NUM_CHAN-1:0] regs_q;
  durd_pkg::durd_cfg_t cur_cfg;
  durd_pkg::durd_cfg_t other_cfg;
  durd_pkg::durd_stat_t cur_stat;
  durd_pkg::durd_tgt_t rd_tgt;
  durd_pkg::durd_tgt_t wr_tgt;
  logic enh_en;
  logic [7:0] rd_mux;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_b_q <= durd_pkg::RST_STROBE;
      wr_b_q <= durd_pkg::RST_STROBE;
    end else begin
      rd_b_q <= rd_b;
      wr_b_q <= wr_b;
    end
  end

  // Act once per strobe; a write overlapping a read is dropped as ambiguous
  assign rd_go = !cs_b && !rd_b && rd_b_q;
  assign wr_go = !cs_b && !wr_b && wr_b_q && rd_b;
  assign ch_hit = channel_select ? 2'b10 : 2'b01;
  assign cur_cfg = regs_q[channel_select];
  assign other_cfg = regs_q[~channel_select];
  assign cur_stat = chan_stat[channel_select];
  assign enh_en = cur_cfg.enhanced_function[durd_pkg::ENH_EN_BIT];
  assign rd_tgt = decode(1'b0, reg_addr, cur_cfg);
  assign wr_tgt = decode(1'b1, reg_addr, cur_cfg);

  // ************************************************************
  // Stored registers
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      regs_q <= {durd_pkg::NUM_CHAN{durd_pkg::CFG_RESET}};
    end else if (wr_go) begin
      case (wr_tgt)
        durd_pkg::TGT_LINE_CTRL: regs_q[channel_select].line_control <= wr_data;
        durd_pkg::TGT_DIV_LO: regs_q[channel_select].divisor_low_byte <= wr_data;
        durd_pkg::TGT_DIV_HI: regs_q[channel_select].divisor_high_byte <= wr_data;
        durd_pkg::TGT_ALT_FUNC: regs_q[channel_select].alternate_function <= wr_data;
        durd_pkg::TGT_INT_EN: begin
          regs_q[channel_select].interrupt_enable <=
            gate(wr_data, durd_pkg::INT_EN_GATE, enh_en);
        end
        durd_pkg::TGT_MODEM_CTRL: begin
          regs_q[channel_select].modem_control <=
            gate(wr_data, durd_pkg::MODEM_CTRL_GATE, enh_en);
        end
        durd_pkg::TGT_SCRATCH: regs_q[channel_select].scratch_pad <= wr_data;
        durd_pkg::TGT_FEAT_CTRL: regs_q[channel_select].feature_control <= wr_data;
        durd_pkg::TGT_ENH_FUNC: regs_q[channel_select].enhanced_function <= wr_data;
        durd_pkg::TGT_RESUME1: regs_q[channel_select].resume_char_one <= wr_data;
        durd_pkg::TGT_RESUME2: regs_q[channel_select].resume_char_two <= wr_data;
        durd_pkg::TGT_PAUSE1: regs_q[channel_select].pause_char_one <= wr_data;
        durd_pkg::TGT_PAUSE2: regs_q[channel_select].pause_char_two <= wr_data;
        // Strobe-only targets and reserved addresses leave storage alone
        default: regs_q <= regs_q;
      endcase
    end
  end

  property p_line_ctrl_wr;
    wr_go && (reg_addr == durd_pkg::ADR_LINE_CTRL)
      |=> regs_q[$past(channel_select)].line_control == $past(wr_data);
  endproperty
  a_line_ctrl_wr: assert property (p_line_ctrl_wr)
    else $error("line control write lost");

  property p_reserved_wr;
    wr_go && (cur_cfg.line_control != durd_pkg::BANK_KEY) &&
      ((reg_addr == durd_pkg::ADR_LINE_STAT) || (reg_addr == durd_pkg::ADR_MODEM_STAT))
      |=> regs_q == $past(regs_q);
  endproperty
  a_reserved_wr: assert property (p_reserved_wr)
    else $error("reserved write changed state");

  property p_pause_two;
    wr_go && (reg_addr == durd_pkg::ADR_SCRATCH) && (cur_cfg.line_control == durd_pkg::BANK_KEY)
      |=> regs_q[$past(channel_select)].pause_char_two == $past(wr_data);
  endproperty
  a_pause_two: assert property (p_pause_two)
    else $error("pause character two not written");

  property p_channel_iso;
    wr_go |=> regs_q[~$past(channel_select)] == $past(other_cfg);
  endproperty
  a_channel_iso: assert property (p_channel_iso)
    else $error("write leaked to other channel");

  property p_int_en_gate;
    wr_go && (reg_addr == durd_pkg::ADR_INT_EN) && !cur_cfg.line_control[durd_pkg::DIV_EN_BIT]
      && !enh_en
      |=> (regs_q[$past(channel_select)].interrupt_enable & durd_pkg::INT_EN_GATE) == 8'h00;
  endproperty
  a_int_en_gate: assert property (p_int_en_gate)
    else $error("gated enable bits stored");

  // Clearing the enhance bit later must also silence bits stored while it was set
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      chan_cfg_q <= {durd_pkg::NUM_CHAN{durd_pkg::CFG_RESET}};
    end else begin
      for (int i = 0; i < durd_pkg::NUM_CHAN; i++) begin
        chan_cfg_q[i] <= regs_q[i];
        chan_cfg_q[i].interrupt_enable <= gate(regs_q[i].interrupt_enable,
          durd_pkg::INT_EN_GATE, regs_q[i].enhanced_function[durd_pkg::ENH_EN_BIT]);
        chan_cfg_q[i].modem_control <= gate(regs_q[i].modem_control,
          durd_pkg::MODEM_CTRL_GATE, regs_q[i].enhanced_function[durd_pkg::ENH_EN_BIT]);
      end
    end
  end

  property p_cfg_gate;
    !cur_cfg.enhanced_function[durd_pkg::ENH_EN_BIT]
      |=> (chan_cfg_q[$past(channel_select)].interrupt_enable & durd_pkg::INT_EN_GATE) == 8'h00;
  endproperty
  a_cfg_gate: assert property (p_cfg_gate)
    else $error("gated enable bits reach the channel");

  // ************************************************************
  // Read path
  // ************************************************************
  always_comb begin
    rd_mux = 8'h00;
    case (rd_tgt)
      durd_pkg::TGT_RX_HOLD: rd_mux = cur_stat.receive_holding;
      durd_pkg::TGT_DIV_LO: rd_mux = cur_cfg.divisor_low_byte;
      durd_pkg::TGT_DIV_HI: rd_mux = cur_cfg.divisor_high_byte;
      durd_pkg::TGT_ALT_FUNC: rd_mux = cur_cfg.alternate_function;
      durd_pkg::TGT_REVISION: rd_mux = DEV_REVISION;
      durd_pkg::TGT_IDENTITY: rd_mux = DEV_IDENTITY;
      durd_pkg::TGT_INT_EN: begin
        rd_mux = gate(cur_cfg.interrupt_enable, durd_pkg::INT_EN_GATE, enh_en);
      end
      durd_pkg::TGT_INT_STAT: begin
        rd_mux = gate(cur_stat.interrupt_status, durd_pkg::INT_STAT_GATE, enh_en);
      end
      durd_pkg::TGT_LINE_CTRL: rd_mux = cur_cfg.line_control;
      durd_pkg::TGT_MODEM_CTRL: begin
        rd_mux = gate(cur_cfg.modem_control, durd_pkg::MODEM_CTRL_GATE, enh_en);
      end
      durd_pkg::TGT_LINE_STAT: rd_mux = cur_stat.line_status;
      durd_pkg::TGT_MODEM_STAT: rd_mux = cur_stat.modem_status;
      durd_pkg::TGT_SCRATCH: rd_mux = cur_cfg.scratch_pad;
      durd_pkg::TGT_FILL_LEVEL: rd_mux = cur_stat.fifo_fill_level;
      durd_pkg::TGT_ENH_COUNT: rd_mux = cur_stat.enhanced_fifo_count;
      durd_pkg::TGT_FEAT_CTRL: rd_mux = cur_cfg.feature_control;
      durd_pkg::TGT_ENH_FUNC: rd_mux = cur_cfg.enhanced_function;
      durd_pkg::TGT_RESUME1: rd_mux = cur_cfg.resume_char_one;
      durd_pkg::TGT_RESUME2: rd_mux = cur_cfg.resume_char_two;
      durd_pkg::TGT_PAUSE1: rd_mux = cur_cfg.pause_char_one;
      durd_pkg::TGT_PAUSE2: rd_mux = cur_cfg.pause_char_two;
      default: rd_mux = 8'h00;
    endcase
  end

  // Data is captured at the strobe edge and held until the next read
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_q <= durd_pkg::RST_REG;
    end else if (rd_go) begin
      rd_data_q <= rd_mux;
    end
  end

  property p_rx_read;
    rd_go && (reg_addr == durd_pkg::ADR_HOLD) && !cur_cfg.line_control[durd_pkg::DIV_EN_BIT]
      |=> (rd_data_q == $past(cur_stat.receive_holding))
        && chan_evt_q[$past(channel_select)].rx_pop;
  endproperty
  a_rx_read: assert property (p_rx_read)
    else $error("receive data read wrong");

  property p_revision;
    rd_go && (reg_addr == durd_pkg::ADR_HOLD) && cur_cfg.line_control[durd_pkg::DIV_EN_BIT]
      && (cur_cfg.line_control != durd_pkg::BANK_KEY)
      && (cur_cfg.divisor_low_byte == durd_pkg::DIV_ZERO)
      && (cur_cfg.divisor_high_byte == durd_pkg::DIV_ZERO)
      |=> rd_data_q == DEV_REVISION;
  endproperty
  a_revision: assert property (p_revision)
    else $error("revision code not returned");

  property p_int_stat_gate;
    rd_go && (reg_addr == durd_pkg::ADR_INT_STAT) && !cur_cfg.line_control[durd_pkg::DIV_EN_BIT]
      && !enh_en
      |=> (rd_data_q & durd_pkg::INT_STAT_GATE) == 8'h00;
  endproperty
  a_int_stat_gate: assert property (p_int_stat_gate)
    else $error("gated status bits visible");

  property p_scratch_rd;
    rd_go && (reg_addr == durd_pkg::ADR_SCRATCH) && (cur_cfg.line_control != durd_pkg::BANK_KEY)
      && !cur_cfg.feature_control[durd_pkg::SWAP_BIT]
      |=> rd_data_q == $past(cur_cfg.scratch_pad);
  endproperty
  a_scratch_rd: assert property (p_scratch_rd)
    else $error("scratch pad read wrong");

  // ************************************************************
  // Channel event strobes
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      chan_evt_q <= {durd_pkg::NUM_CHAN{durd_pkg::EVT_RESET}};
    end else begin
      for (int i = 0; i < durd_pkg::NUM_CHAN; i++) begin
        chan_evt_q[i].tx_load <= wr_go && ch_hit[i] && (wr_tgt == durd_pkg::TGT_TX_HOLD);
        chan_evt_q[i].fifo_ctrl_load <= wr_go && ch_hit[i] &&
                                        (wr_tgt == durd_pkg::TGT_FIFO_CTRL);
        chan_evt_q[i].trig_load <= wr_go && ch_hit[i] &&
                                   (wr_tgt == durd_pkg::TGT_TRIG_LEVEL);
        chan_evt_q[i].mode_sel_load <= wr_go && ch_hit[i] &&
                                       (wr_tgt == durd_pkg::TGT_MODE_SEL);
        chan_evt_q[i].rx_pop <= rd_go && ch_hit[i] && (rd_tgt == durd_pkg::TGT_RX_HOLD);
        chan_evt_q[i].int_stat_read <= rd_go && ch_hit[i] && (rd_tgt == durd_pkg::TGT_INT_STAT);
        chan_evt_q[i].line_stat_read <= rd_go && ch_hit[i] &&
                                        (rd_tgt == durd_pkg::TGT_LINE_STAT);
        chan_evt_q[i].modem_stat_read <= rd_go && ch_hit[i] &&
                                         (rd_tgt == durd_pkg::TGT_MODEM_STAT);
        if (wr_go && ch_hit[i]) begin
          chan_evt_q[i].wr_data <= (wr_tgt == durd_pkg::TGT_FIFO_CTRL) ?
            gate(wr_data, durd_pkg::FIFO_CTRL_GATE, enh_en) : wr_data;
        end
      end
    end
  end

  property p_tx_load;
    wr_go && (reg_addr == durd_pkg::ADR_HOLD) && !cur_cfg.line_control[durd_pkg::DIV_EN_BIT]
      |=> chan_evt_q[$past(channel_select)].tx_load
        ##1 !chan_evt_q[$past(channel_select, 2)].tx_load;
  endproperty
  a_tx_load: assert property (p_tx_load)
    else $error("transmit load not a single pulse");

  property p_trig_load;
    wr_go && (reg_addr == durd_pkg::ADR_HOLD) && (cur_cfg.line_control == durd_pkg::BANK_KEY)
      |=> chan_evt_q[$past(channel_select)].trig_load
        && (chan_evt_q[$past(channel_select)].wr_data == $past(wr_data));
  endproperty
  a_trig_load: assert property (p_trig_load)
    else $error("trigger level load missing");

  property p_line_stat_evt;
    rd_go && (reg_addr == durd_pkg::ADR_LINE_STAT)
      && (cur_cfg.line_control != durd_pkg::BANK_KEY)
      |=> chan_evt_q[$past(channel_select)].line_stat_read
        && (rd_data_q == $past(cur_stat.line_status));
  endproperty
  a_line_stat_evt: assert property (p_line_stat_evt)
    else $error("line status read wrong");

endmodule

`default_nettype wire

/* logic/durd_pkg.sv */
// Constants and carrier types for the dual-channel register select block
package durd_pkg;

  // ************************************************************
  // Channel and address layout
  // ************************************************************
  localparam int NUM_CHAN = 2;
  localparam logic [2:0] ADR_HOLD = 3'h0;
  localparam logic [2:0] ADR_INT_EN = 3'h1;
  localparam logic [2:0] ADR_INT_STAT = 3'h2;
  localparam logic [2:0] ADR_LINE_CTRL = 3'h3;
  localparam logic [2:0] ADR_MODEM_CTRL = 3'h4;
  localparam logic [2:0] ADR_LINE_STAT = 3'h5;
  localparam logic [2:0] ADR_MODEM_STAT = 3'h6;
  localparam logic [2:0] ADR_SCRATCH = 3'h7;

  // ************************************************************
  // Field positions and key values
  // ************************************************************
  localparam logic [7:0] BANK_KEY = 8'hBF;
  localparam logic [7:0] DIV_ZERO = 8'h00;
  localparam int DIV_EN_BIT = 7;
  localparam int SWAP_BIT = 6;
  localparam int ENH_EN_BIT = 4;
  localparam logic [7:0] INT_EN_GATE = 8'hF0;
  localparam logic [7:0] INT_STAT_GATE = 8'h30;
  localparam logic [7:0] FIFO_CTRL_GATE = 8'h30;
  localparam logic [7:0] MODEM_CTRL_GATE = 8'hE0;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic RST_STROBE = 1'b1;

  // ************************************************************
  // Register targets
  // ************************************************************
  typedef enum logic [4:0] {
    TGT_NONE, TGT_RX_HOLD, TGT_TX_HOLD, TGT_DIV_LO, TGT_DIV_HI, TGT_ALT_FUNC,
    TGT_REVISION, TGT_IDENTITY, TGT_INT_EN, TGT_INT_STAT, TGT_FIFO_CTRL,
    TGT_LINE_CTRL, TGT_MODEM_CTRL, TGT_LINE_STAT, TGT_MODEM_STAT, TGT_SCRATCH,
    TGT_FILL_LEVEL, TGT_MODE_SEL, TGT_TRIG_LEVEL, TGT_ENH_COUNT, TGT_FEAT_CTRL,
    TGT_ENH_FUNC, TGT_RESUME1, TGT_RESUME2, TGT_PAUSE1, TGT_PAUSE2
  } durd_tgt_t;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [7:0] receive_holding;
    logic [7:0] interrupt_status;
    logic [7:0] line_status;
    logic [7:0] modem_status;
    logic [7:0] fifo_fill_level;
    logic [7:0] enhanced_fifo_count;
  } durd_stat_t;

  typedef struct packed {
    logic [7:0] line_control;
    logic [7:0] divisor_low_byte;
    logic [7:0] divisor_high_byte;
    logic [7:0] alternate_function;
    logic [7:0] interrupt_enable;
    logic [7:0] modem_control;
    logic [7:0] scratch_pad;
    logic [7:0] feature_control;
    logic [7:0] enhanced_function;
    logic [7:0] resume_char_one;
    logic [7:0] resume_char_two;
    logic [7:0] pause_char_one;
    logic [7:0] pause_char_two;
  } durd_cfg_t;

  typedef struct packed {
    logic tx_load;
    logic fifo_ctrl_load;
    logic trig_load;
    logic mode_sel_load;
    logic rx_pop;
    logic int_stat_read;
    logic line_stat_read;
    logic modem_stat_read;
    logic [7:0] wr_data;
  } durd_evt_t;

  localparam durd_cfg_t CFG_RESET = '{default: RST_REG};
  localparam durd_evt_t EVT_RESET = '{default: '0};

endpackage

/* testbench/durd_host.sv */
// Host bus master model driving the register select block
`timescale 1ns/1ps
`default_nettype none

module durd_host (
  // Clock
  input wire logic clk_sys,
  // Host bus
  output logic cs_b,
  output logic channel_select,
  output logic [2:0] reg_addr,
  output logic rd_b,
  output logic wr_b,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data_q
);
  initial begin
    cs_b = 1'b1;
    channel_select = 1'b0;
    reg_addr = 3'h0;
    rd_b = 1'b1;
    wr_b = 1'b1;
    wr_data = 8'h00;
  end

  // Strobe is held until the taking edge, then released; next access waits one edge
  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    cs_b = 1'b0;
    channel_select = ch;
    reg_addr = a;
    wr_data = d;
    wr_b = 1'b0;
    @(posedge clk_sys);
    #1;
    wr_b = 1'b1;
    cs_b = 1'b1;
    // Released data must not look like the last value
    wr_data = ~d;
  endtask

  task automatic rd(input logic ch, input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    cs_b = 1'b0;
    channel_select = ch;
    reg_addr = a;
    rd_b = 1'b0;
    @(posedge clk_sys);
    @(posedge clk_sys);
    #1;
    d = rd_data_q;
    rd_b = 1'b1;
    cs_b = 1'b1;
  endtask
endmodule

`default_nettype wire

/* testbench/dual_uart_register_decode_tb.sv */
// Self-checking bench for the register select block
`timescale 1ns/1ps
`default_nettype none

module dual_uart_register_decode_tb;
  // Arbitrary code values
  localparam logic [7:0] REV = 8'h5A;
  localparam logic [7:0] IDN = 8'hC3;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  wire logic cs_b, channel_select, rd_b, wr_b;
  wire logic [2:0] reg_addr;
  wire logic [7:0] wr_data, rd_data_q;
  durd_pkg::durd_stat_t [1:0] stat;
  durd_pkg::durd_cfg_t [1:0] cfg;
  durd_pkg::durd_evt_t [1:0] evt;
  durd_pkg::durd_cfg_t saved;
  int bad_count = 0;
  int n_compared = 0;

  always #4 clk_sys = ~clk_sys;

  durd_regsel #(.DEV_REVISION(REV), .DEV_IDENTITY(IDN)) durd_regsel_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .cs_b(cs_b), .channel_select(channel_select),
    .reg_addr(reg_addr), .rd_b(rd_b), .wr_b(wr_b), .wr_data(wr_data),
    .rd_data_q(rd_data_q), .chan_stat(stat), .chan_cfg_q(cfg), .chan_evt_q(evt));

  durd_host durd_host_i (
    .clk_sys(clk_sys), .cs_b(cs_b), .channel_select(channel_select), .reg_addr(reg_addr),
    .rd_b(rd_b), .wr_b(wr_b), .wr_data(wr_data), .rd_data_q(rd_data_q));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdc(input logic ch, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    durd_host_i.rd(ch, a, d);
    check(d, exp);
  endtask

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_normal;
    check({7'h0, cfg[0] === durd_pkg::CFG_RESET}, 8'h01);
    durd_host_i.wr(1'b0, 3'h0, 8'h5C);
    check({7'h0, evt[0].tx_load}, 8'h01);
    check(evt[0].wr_data, 8'h5C);
    rdc(1'b0, 3'h0, 8'hA1);
    durd_host_i.wr(1'b0, 3'h1, 8'hFF);
    rdc(1'b0, 3'h1, 8'h0F);
    rdc(1'b0, 3'h2, 8'hCF);
    durd_host_i.wr(1'b0, 3'h2, 8'hFF);
    check({7'h0, evt[0].fifo_ctrl_load}, 8'h01);
    check(evt[0].wr_data, 8'hCF);
    durd_host_i.wr(1'b0, 3'h4, 8'hFF);
    rdc(1'b0, 3'h4, 8'h1F);
    rdc(1'b0, 3'h5, 8'h65);
    rdc(1'b0, 3'h6, 8'hB3);
    durd_host_i.wr(1'b0, 3'h7, 8'h9E);
    rdc(1'b0, 3'h7, 8'h9E);
    saved = cfg[0];
    durd_host_i.wr(1'b0, 3'h5, 8'hFF);
    durd_host_i.wr(1'b0, 3'h6, 8'hFF);
    repeat (2) @(posedge clk_sys);
    #1;
    check({7'h0, cfg[0] === saved}, 8'h01);
  endtask

  task automatic t_divisor;
    durd_host_i.wr(1'b0, 3'h3, 8'h80);
    rdc(1'b0, 3'h0, REV);
    rdc(1'b0, 3'h1, IDN);
    durd_host_i.wr(1'b0, 3'h0, 8'h12);
    rdc(1'b0, 3'h0, 8'h12);
    rdc(1'b0, 3'h1, 8'h00);
    durd_host_i.wr(1'b0, 3'h2, 8'h07);
    rdc(1'b0, 3'h2, 8'h07);
  endtask

  task automatic t_bank;
    durd_host_i.wr(1'b0, 3'h3, 8'hBF);
    rdc(1'b0, 3'h3, 8'hBF);
    durd_host_i.wr(1'b0, 3'h1, 8'h40);
    durd_host_i.wr(1'b0, 3'h2, 8'h10);
    rdc(1'b0, 3'h1, 8'h40);
    rdc(1'b0, 3'h2, 8'h10);
    for (int a = 4; a < 8; a++) durd_host_i.wr(1'b0, 3'(a), 8'(8'hC0 + a));
    for (int a = 4; a < 8; a++) rdc(1'b0, 3'(a), 8'(8'hC0 + a));
    check(cfg[0].pause_char_two, 8'hC7);
    durd_host_i.wr(1'b0, 3'h0, 8'h33);
    check({7'h0, evt[0].trig_load}, 8'h01);
    rdc(1'b0, 3'h0, 8'h7D);
  endtask

  task automatic t_enhanced;
    durd_host_i.wr(1'b0, 3'h3, 8'h03);
    rdc(1'b0, 3'h7, 8'h4E);
    durd_host_i.wr(1'b0, 3'h7, 8'h55);
    check({7'h0, evt[0].mode_sel_load}, 8'h01);
    durd_host_i.wr(1'b0, 3'h1, 8'hFF);
    rdc(1'b0, 3'h1, 8'hFF);
    rdc(1'b0, 3'h2, 8'hFF);
    durd_host_i.wr(1'b1, 3'h7, 8'h21);
    rdc(1'b1, 3'h7, 8'h21);
    rdc(1'b1, 3'h0, 8'h1A);
    check(cfg[0].scratch_pad, 8'h9E);
    durd_host_i.wr(1'b1, 3'h0, 8'h77);
    check({6'h0, evt[1].tx_load, evt[0].tx_load}, 8'h02);
    // Dropping the enhance bit later must hide bits stored while it was set
    durd_host_i.wr(1'b0, 3'h3, 8'hBF);
    durd_host_i.wr(1'b0, 3'h2, 8'h00);
    durd_host_i.wr(1'b0, 3'h3, 8'h03);
    rdc(1'b0, 3'h1, 8'h0F);
    rdc(1'b0, 3'h2, 8'hCF);
    check(cfg[0].interrupt_enable, 8'h0F);
  endtask

  initial begin
    stat[0] = '{8'hA1, 8'hFF, 8'h65, 8'hB3, 8'h4E, 8'h7D};
    stat[1] = '{8'h1A, 8'h01, 8'h60, 8'h30, 8'h02, 8'h03};
    repeat (16) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    repeat (2) @(posedge clk_sys);
    t_normal();
    t_divisor();
    t_bank();
    t_enhanced();
    print_verdict();
  end

  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end
endmodule

`default_nettype wire
